// ---- rtl/gbh_host.sv ----
// host controller that drives the graphic bus port and its dma channel
// What this block does
// - init ports to zero, port6 special 0x06
// - start only when all three flags zero
// - dma write: set flag, first byte, enable
// - dma read: set flag, dummy read, enable
// - toward bus: direction one, address plus one
// - from bus: direction zero, address first
// - clearing enable stalls, setting resumes
// - clear pending and enable in separate writes
// - terminate: disable, then clear pending, and bypass too when data bit 0 is set
// - untriggered external start: count plus one
`timescale 1ns/1ps
module gbh_host
	import gbh_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        cmd_valid,
	input  wire gbh_order_t  cmd_order,
	output logic             cmd_ready,
	output logic             cmd_done,
	output logic             cmd_refused,
	output logic [7:0]       rd_data,
	input  wire logic        reg_ack,
	input  wire logic [31:0] reg_rdata,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [7:0]       reg_addr,
	output logic [31:0]      reg_wdata
);

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_CHECK   = 3'b001,
		ST_CHECK_W = 3'b011,
		ST_STEP    = 3'b010,
		ST_STEP_W  = 3'b110,
		ST_POLL    = 3'b111,
		ST_POLL_W  = 3'b101,
		ST_FINISH  = 3'b100
	} gbh_state_t;

	gbh_state_t  state;
	gbh_order_t  o;
	logic [3:0]  step;
	logic        acc_valid;
	gbh_req_t    acc_req;
	logic        acc_done;
	logic [31:0] acc_rdata;
	gbh_op_t     op;
	logic [3:0]  sh_tim;
	logic        sh_e;
	logic        sh_dir;
	logic [3:0]  sh_trigger_select_field;
	logic [7:0]  sh_dma_timer_field;
	logic        flags_ok;
	logic        dta_set;
	logic        last_mode_en;

	function automatic logic [31:0] ctl_word(input logic [3:0] tim,
		input logic e, input logic transfer_active_flag);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[CTL_TIM_LSB +: 4] = tim;
		w[CTL_E_BIT] = e;
		w[CTL_DTA_BIT] = transfer_active_flag;
		return w;
	endfunction

	// pending bit is written one unless a clear is wanted, as zero clears it
	function automatic logic [31:0] mode_word(input logic en,
		input logic keep_p, input logic bypass_control_bit, input logic dir,
		input logic [3:0] trigger_select_field, input logic [7:0] dma_timer_field);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[CH_EN_BIT] = en;
		w[CH_P_BIT] = keep_p;
		w[CH_BYP_BIT] = bypass_control_bit;
		w[CH_DIR_BIT] = dir;
		w[CH_MAS_LSB +: 2] = MAS_8BIT;
		w[CH_TRIGGER_SELECT_FIELD_LSB +: 4] = trigger_select_field;
		w[CH_DMA_TIMER_FIELD_LSB +: 8] = dma_timer_field;
		return w;
	endfunction

	function automatic logic needs_check(input gbh_cmd_t c);
		return (c == CMD_WRITE) || (c == CMD_READ_START) ||
			(c == CMD_DMA_WRITE) || (c == CMD_DMA_READ) || (c == CMD_OFF);
	endfunction

	function automatic logic needs_poll(input gbh_cmd_t c);
		return (c == CMD_WRITE) || (c == CMD_READ_START);
	endfunction

	function automatic logic is_dma(input gbh_cmd_t c);
		return (c == CMD_DMA_WRITE) || (c == CMD_DMA_READ);
	endfunction

	// at most one register access per step of the current order
	always_comb begin
		op = '0;
		op.last = 1'b1;
		case (o.cmd)
		CMD_INIT: begin
			op.last = (step == INIT_LAST);
			op.req.wr = 1'b1;
			op.req.addr = INIT_ADDR[step];
			if (step == INIT_LAST) begin
				op.req.data = ctl_word(o.tim, 1'b1, 1'b0);
			end else begin
				op.req.data = {24'h000000, INIT_DATA[step]};
			end
		end
		CMD_OFF: begin
			op.req.wr = 1'b1;
			op.req.addr = OFS_CTRL;
			op.req.data = ctl_word(TIM_OFF, sh_e, 1'b0);
		end
		CMD_WRITE: begin
			op.req.wr = 1'b1;
			op.req.addr = OFS_DATA;
			op.req.data = {24'h000000, o.data};
		end
		CMD_READ_START, CMD_READ_FETCH: begin
			op.req.addr = OFS_DATA;
		end
		CMD_STATUS: begin
			op.req.addr = OFS_CTRL;
		end
		CMD_DMA_WRITE, CMD_DMA_READ: begin
			op.last = (step == 4'h4);
			op.req.wr = 1'b1;
			case (step)
			4'h0: begin
				op.req.addr = OFS_CHMODE;
				op.req.data = mode_word(1'b0, 1'b1, 1'b1,
					o.cmd == CMD_DMA_WRITE, o.trigger_select_field, o.dma_timer_field);
			end
			4'h1: begin
				op.req.addr = OFS_VECTOR;
				op.req.data[VEC_ADDR_LSB +: 24] = (o.cmd == CMD_DMA_WRITE)
					? 24'(o.addr + 24'h000001) : o.addr;
				op.req.data[VEC_CNT_LSB +: 8] = o.ext
					? 8'(o.count + 8'h01) : o.count;
			end
			4'h2: begin
				op.req.addr = OFS_CTRL;
				op.req.data = ctl_word(sh_tim, sh_e, 1'b1);
			end
			4'h3: begin
				// external trigger without a first access skips it
				op.skip = o.ext;
				op.req.wr = (o.cmd == CMD_DMA_WRITE);
				op.req.addr = OFS_DATA;
				op.req.data = {24'h000000, o.data};
			end
			default: begin
				op.req.addr = OFS_CHMODE;
				op.req.data = mode_word(1'b1, 1'b1, 1'b1,
					o.cmd == CMD_DMA_WRITE, o.trigger_select_field, o.dma_timer_field);
			end
			endcase
		end
		CMD_STALL, CMD_RESUME: begin
			op.req.wr = 1'b1;
			op.req.addr = OFS_CHMODE;
			op.req.data = mode_word(o.cmd == CMD_RESUME, 1'b1, 1'b1,
				sh_dir, sh_trigger_select_field, sh_dma_timer_field);
		end
		CMD_TERMINATE: begin
			op.last = (step == 4'h1);
			op.req.wr = 1'b1;
			op.req.addr = OFS_CHMODE;
			// pending cleared only after the channel is already off
			op.req.data = mode_word(1'b0, step == 4'h0,
				(step == 4'h0) || !o.data[0], sh_dir, 4'h0,
				sh_dma_timer_field);
		end
		default: begin
			op.skip = 1'b1;
		end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			o <= '0;
			step <= 4'h0;
			acc_valid <= 1'b0;
			acc_req <= '0;
		end else begin
			acc_valid <= 1'b0;
			case (state)
			ST_IDLE: begin
				step <= 4'h0;
				if (cmd_valid) begin
					o <= cmd_order;
					state <= needs_check(cmd_order.cmd) ? ST_CHECK : ST_STEP;
				end
			end
			ST_CHECK, ST_POLL: begin
				acc_valid <= 1'b1;
				acc_req <= '{wr: 1'b0, addr: OFS_CTRL, data: 32'h0};
				state <= (state == ST_CHECK) ? ST_CHECK_W : ST_POLL_W;
			end
			ST_CHECK_W: begin
				if (acc_done) begin
					// any set flag means a transfer is still in flight
					if (acc_rdata[CTL_BSY_BIT] || acc_rdata[CTL_SEQ_BIT] ||
						acc_rdata[CTL_DTA_BIT]) begin
						state <= ST_IDLE;
					end else begin
						state <= ST_STEP;
					end
				end
			end
			ST_STEP: begin
				if (op.skip) begin
					step <= 4'(step + 4'h1);
					state <= op.last ? ST_FINISH : ST_STEP;
				end else begin
					acc_valid <= 1'b1;
					acc_req <= op.req;
					state <= ST_STEP_W;
				end
			end
			ST_STEP_W: begin
				if (acc_done) begin
					step <= 4'(step + 4'h1);
					if (!op.last) begin
						state <= ST_STEP;
					end else if (needs_poll(o.cmd)) begin
						state <= ST_POLL;
					end else begin
						state <= ST_FINISH;
					end
				end
			end
			ST_POLL_W: begin
				if (acc_done) begin
					// busy drops once the strobe timing is over
					state <= acc_rdata[CTL_BSY_BIT] ? ST_POLL
						: ST_FINISH;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// shadows of what init, off and dma setup last wrote, for later partial updates
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sh_tim <= TIM_OFF;
			sh_e <= 1'b0;
			sh_dir <= 1'b0;
			sh_trigger_select_field <= 4'h0;
			sh_dma_timer_field <= 8'h00;
		end else if (state == ST_STEP_W && acc_done) begin
			if (o.cmd == CMD_INIT && op.last) begin
				sh_tim <= o.tim;
				sh_e <= 1'b1;
			end
			if (o.cmd == CMD_OFF) begin
				sh_tim <= TIM_OFF;
			end
			if (is_dma(o.cmd) && step == 4'h0) begin
				sh_dir <= (o.cmd == CMD_DMA_WRITE);
				sh_trigger_select_field <= o.trigger_select_field;
				sh_dma_timer_field <= o.dma_timer_field;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmd_ready <= 1'b0;
			cmd_done <= 1'b0;
			cmd_refused <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			cmd_ready <= (state == ST_IDLE) && !cmd_valid;
			cmd_done <= (state == ST_FINISH);
			cmd_refused <= (state == ST_CHECK_W) && acc_done &&
				(acc_rdata[CTL_BSY_BIT] || acc_rdata[CTL_SEQ_BIT] ||
				acc_rdata[CTL_DTA_BIT]);
			if (state == ST_STEP_W && acc_done && !op.req.wr) begin
				rd_data <= acc_rdata[7:0];
			end
		end
	end

	// helper state watched only by the checks below
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flags_ok <= 1'b0;
			dta_set <= 1'b0;
			last_mode_en <= 1'b0;
		end else begin
			if (state == ST_IDLE) begin
				flags_ok <= 1'b0;
				dta_set <= 1'b0;
			end else if (state == ST_CHECK_W && acc_done) begin
				flags_ok <= 1'b1;
			end
			if (acc_valid && acc_req.wr && acc_req.addr == OFS_CTRL) begin
				dta_set <= acc_req.data[CTL_DTA_BIT];
			end
			if (acc_valid && acc_req.wr && acc_req.addr == OFS_CHMODE) begin
				last_mode_en <= acc_req.data[CH_EN_BIT];
			end
		end
	end

	gbh_reg_access u_access (
		.clock     (clock),
		.rst       (rst),
		.req_valid (acc_valid),
		.req       (acc_req),
		.reg_ack   (reg_ack),
		.reg_rdata (reg_rdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.done      (acc_done),
		.rdata     (acc_rdata)
	);

	property p_port6_special_select_special;
		@(posedge clock) disable iff (rst)
		acc_valid && acc_req.wr && acc_req.addr == OFS_PORT6_SPECIAL_SELECT
			|-> acc_req.data[7:0] == PORT6_SPECIAL;
	endproperty
	a_port6_special_select_special: assert property (p_port6_special_select_special)
		else $error("port6 special select not 0x06");

	property p_tri_out;
		@(posedge clock) disable iff (rst)
		acc_valid && acc_req.wr && (acc_req.addr == OFS_U5TRI ||
			acc_req.addr == OFS_U7TRI || acc_req.addr == OFS_U6TRI)
			|-> acc_req.data[7:0] == PORT_TRI_OUT;
	endproperty
	a_tri_out: assert property (p_tri_out)
		else $error("tristate register not set to output");

	property p_start_gated;
		@(posedge clock) disable iff (rst)
		acc_valid && acc_req.addr == OFS_DATA && needs_check(o.cmd)
			|-> flags_ok && $past(state, 2) != ST_IDLE;
	endproperty
	a_start_gated: assert property (p_start_gated)
		else $error("transfer started without clear flags");

	property p_en_keeps_p;
		@(posedge clock) disable iff (rst)
		acc_valid && acc_req.wr && acc_req.addr == OFS_CHMODE &&
			acc_req.data[CH_EN_BIT] |-> acc_req.data[CH_P_BIT];
	endproperty
	a_en_keeps_p: assert property (p_en_keeps_p)
		else $error("pending cleared in same write as enable");

	property p_write_dir;
		@(posedge clock) disable iff (rst)
		acc_valid && o.cmd == CMD_DMA_WRITE && acc_req.addr == OFS_CHMODE
			|-> acc_req.data[CH_DIR_BIT] && acc_req.data[CH_BYP_BIT];
	endproperty
	a_write_dir: assert property (p_write_dir)
		else $error("dma write setup has wrong direction or bypass");

	property p_read_dir;
		@(posedge clock) disable iff (rst)
		acc_valid && o.cmd == CMD_DMA_READ && acc_req.addr == OFS_CHMODE
			|-> !acc_req.data[CH_DIR_BIT];
	endproperty
	a_read_dir: assert property (p_read_dir)
		else $error("dma read setup has wrong direction");

	property p_ext_count;
		@(posedge clock) disable iff (rst)
		acc_valid && is_dma(o.cmd) && acc_req.addr == OFS_VECTOR
			|-> acc_req.data[VEC_CNT_LSB +: 8] ==
				(o.ext ? 8'(o.count + 8'h01) : o.count);
	endproperty
	a_ext_count: assert property (p_ext_count)
		else $error("vector count wrong for trigger mode");

	property p_dma_first_after_dta;
		@(posedge clock) disable iff (rst)
		acc_valid && is_dma(o.cmd) && acc_req.addr == OFS_DATA
			|-> dta_set ##1 !acc_valid [*2];
	endproperty
	a_dma_first_after_dta: assert property (p_dma_first_after_dta)
		else $error("first dma access before transfer-active set");

	property p_dma_en_last;
		@(posedge clock) disable iff (rst)
		acc_valid && is_dma(o.cmd) && acc_req.addr == OFS_CHMODE &&
			acc_req.data[CH_EN_BIT] |-> dta_set && (o.ext ||
			$past(acc_req.addr, 1) == OFS_DATA);
	endproperty
	a_dma_en_last: assert property (p_dma_en_last)
		else $error("channel enabled before first access");

	property p_pclear_after_off;
		@(posedge clock) disable iff (rst)
		acc_valid && acc_req.wr && acc_req.addr == OFS_CHMODE &&
			!acc_req.data[CH_P_BIT] |-> !last_mode_en &&
			!acc_req.data[CH_EN_BIT];
	endproperty
	a_pclear_after_off: assert property (p_pclear_after_off)
		else $error("pending cleared while channel enabled");

	property p_stall_disables;
		@(posedge clock) disable iff (rst)
		acc_valid && o.cmd == CMD_STALL |-> !acc_req.data[CH_EN_BIT];
	endproperty
	a_stall_disables: assert property (p_stall_disables)
		else $error("stall did not clear channel enable");

endmodule

// ---- rtl/gbh_pkg.sv ----
// shared constants and types for the graphic bus host controller
package gbh_pkg;

	// register offsets on the device's register port
	localparam logic [7:0] OFS_U5MODE = 8'h00;
	localparam logic [7:0] OFS_U7MODE = 8'h04;
	localparam logic [7:0] OFS_U6MODE = 8'h08;
	localparam logic [7:0] OFS_U5NS   = 8'h0c;
	localparam logic [7:0] OFS_U7NS   = 8'h10;
	localparam logic [7:0] OFS_PORT6_SPECIAL_SELECT   = 8'h14;
	localparam logic [7:0] OFS_U5TRI  = 8'h18;
	localparam logic [7:0] OFS_U7TRI  = 8'h1c;
	localparam logic [7:0] OFS_U6TRI  = 8'h20;
	localparam logic [7:0] OFS_CTRL   = 8'h24;
	localparam logic [7:0] OFS_DATA   = 8'h28;
	localparam logic [7:0] OFS_CHMODE = 8'h2c;
	localparam logic [7:0] OFS_VECTOR = 8'h30;

	// port configuration values
	localparam logic [7:0] PORT_MODE_VAL = 8'h00;
	localparam logic [7:0] PORT_NS_VAL   = 8'h00;
	localparam logic [7:0] PORT6_SPECIAL = 8'h06;
	localparam logic [7:0] PORT_TRI_OUT  = 8'h00;

	// bus_control_status fields
	localparam int CTL_TIM_LSB = 0;
	localparam int CTL_E_BIT   = 4;
	localparam int CTL_BSY_BIT = 5;
	localparam int CTL_SEQ_BIT = 6;
	localparam int CTL_DTA_BIT = 7;
	localparam logic [3:0] TIM_OFF = 4'h0;

	// channel_mode_reg fields
	localparam int CH_EN_BIT    = 0;
	localparam int CH_P_BIT     = 1;
	localparam int CH_BYP_BIT   = 2;
	localparam int CH_DIR_BIT   = 3;
	localparam int CH_MAS_LSB   = 4;
	localparam int CH_TRIGGER_SELECT_FIELD_LSB  = 6;
	localparam int CH_DMA_TIMER_FIELD_LSB  = 10;
	localparam logic [1:0] MAS_8BIT = 2'h0;

	// dma vector word fields
	localparam int VEC_CNT_LSB  = 0;
	localparam int VEC_ADDR_LSB = 8;

	// init sequence table
	localparam logic [3:0] INIT_LAST = 4'h9;
	localparam logic [7:0] INIT_ADDR [10] = '{OFS_U5MODE, OFS_U7MODE,
		OFS_U6MODE, OFS_U5NS, OFS_U7NS, OFS_PORT6_SPECIAL_SELECT, OFS_U5TRI, OFS_U7TRI,
		OFS_U6TRI, OFS_CTRL};
	localparam logic [7:0] INIT_DATA [9] = '{PORT_MODE_VAL, PORT_MODE_VAL,
		PORT_MODE_VAL, PORT_NS_VAL, PORT_NS_VAL, PORT6_SPECIAL,
		PORT_TRI_OUT, PORT_TRI_OUT, PORT_TRI_OUT};

	typedef enum logic [3:0] {
		CMD_INIT       = 4'h0,
		CMD_OFF        = 4'h1,
		CMD_WRITE      = 4'h2,
		CMD_READ_START = 4'h3,
		CMD_READ_FETCH = 4'h4,
		CMD_DMA_WRITE  = 4'h5,
		CMD_DMA_READ   = 4'h6,
		CMD_STALL      = 4'h7,
		CMD_RESUME     = 4'h8,
		CMD_TERMINATE  = 4'h9,
		CMD_STATUS     = 4'ha
	} gbh_cmd_t;

	typedef struct packed {
		gbh_cmd_t    cmd;
		logic [7:0]  data;
		logic [23:0] addr;
		logic [7:0]  count;
		logic        ext;
		logic [3:0]  tim;
		logic [3:0]  trigger_select_field;
		logic [7:0]  dma_timer_field;
	} gbh_order_t;

	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] data;
	} gbh_req_t;

	typedef struct packed {
		logic     skip;
		logic     last;
		gbh_req_t req;
	} gbh_op_t;

endpackage

// ---- rtl/gbh_reg_access.sv ----
// single register access engine toward the device register port
`timescale 1ns/1ps
module gbh_reg_access
	import gbh_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        req_valid,
	input  wire gbh_req_t    req,
	input  wire logic        reg_ack,
	input  wire logic [31:0] reg_rdata,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [7:0]       reg_addr,
	output logic [31:0]      reg_wdata,
	output logic             done,
	output logic [31:0]      rdata
);

	// strobe is a level held until the device acknowledges
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
			reg_addr <= 8'h00;
			reg_wdata <= 32'h0000_0000;
		end else if ((reg_wr || reg_rd) && reg_ack) begin
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
		end else if (req_valid && !reg_wr && !reg_rd) begin
			reg_wr <= req.wr;
			reg_rd <= !req.wr;
			reg_addr <= req.addr;
			reg_wdata <= req.data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			done <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			done <= (reg_wr || reg_rd) && reg_ack;
			if (reg_rd && reg_ack) begin
				rdata <= reg_rdata;
			end
		end
	end

endmodule

// ---- tb/gbh_dev_model.sv ----
// behavioural model of the graphic bus device and its register port
`timescale 1ns/1ps
module gbh_dev_model
	import gbh_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        slow,
	input  wire logic [7:0]  pin_byte,
	input  wire logic        seq_end,
	output logic             reg_ack,
	output logic [31:0]      reg_rdata
);
	logic [31:0] regs [16];
	logic [31:0] rd_q;
	logic [31:0] rd_val;
	logic [7:0]  p5;
	logic [7:0]  p7;
	logic [7:0]  wr_cnt;
	logic [7:0]  rd_cnt;
	logic [16:0] bsy_cnt;
	logic [1:0]  wait_cnt;
	logic [7:0]  dma_cnt;
	logic        seq;
	logic        transfer_active_flag;
	logic [3:0]  idx;
	logic        busy_flag;

	assign idx = reg_addr[5:2];
	assign busy_flag = (bsy_cnt != 17'h0);
	// released read bus shows the inverse so stale data cannot pass
	assign reg_rdata = reg_ack ? rd_q : ~rd_q;

	always_comb begin
		case (idx)
			4'h9: rd_val = {24'h0, transfer_active_flag, seq, busy_flag, regs[9][4:0]};
			4'ha: rd_val = {24'h0, pin_byte};
			default: rd_val = regs[idx];
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				regs[i] <= (i < 9) ? 32'hffffffff : 32'h0;
			end
			{rd_q, p5, p7, wr_cnt, rd_cnt} <= '0;
			{bsy_cnt, wait_cnt, seq, transfer_active_flag, reg_ack, dma_cnt} <= '0;
		end else begin
			reg_ack <= 1'b0;
			if (busy_flag) begin
				bsy_cnt <= bsy_cnt - 17'h1;
			end
			if (seq_end) begin
				seq <= 1'b0;
				transfer_active_flag <= 1'b0;
				regs[11][0] <= 1'b0;
			end
			// final request acks once only when steered to the channel
			if (seq_end && regs[11][0] && regs[11][2]) begin
				dma_cnt <= dma_cnt + 8'h1;
			end
			if ((reg_wr | reg_rd) && !reg_ack) begin
				if (wait_cnt < (slow ? 2'h3 : 2'h0)) begin
					wait_cnt <= wait_cnt + 2'h1;
				end else begin
					wait_cnt <= 2'h0;
					reg_ack <= 1'b1;
					rd_q <= rd_val;
					if (idx == 4'ha) begin
						seq <= 1'b1;
						// strobe period of 2^(tim+1) clocks, none if off
						if (regs[9][4] && regs[9][3:0] != 4'h0) begin
							// shortest period is four clocks
							bsy_cnt <= 17'h1 << (5'(regs[9][3:0]) + 5'h1);
						end
					end
					if (reg_rd && idx == 4'ha) begin
						rd_cnt <= rd_cnt + 8'h1;
					end
					if (reg_wr) begin
						case (idx)
							4'h9: begin
								regs[9] <= {27'h0, reg_wdata[4:0]};
								transfer_active_flag <= transfer_active_flag | reg_wdata[7];
							end
							4'ha: begin
								p5[3:0] <= reg_wdata[3:0];
								p7[7:4] <= reg_wdata[7:4];
								wr_cnt <= wr_cnt + 8'h1;
							end
							// nothing is ever pending, so P reads zero
							4'hb: regs[11] <= {reg_wdata[31:2], 1'b0,
								reg_wdata[0]};
							default: regs[idx] <= reg_wdata;
						endcase
					end
				end
			end
		end
	end
endmodule

// ---- tb/graphic_bus_dma_port_tb_top.sv ----
// self-checking bench for the graphic bus host controller
`timescale 1ns/1ps
module graphic_bus_dma_port_tb_top
	import gbh_pkg::*;
;
	logic        clock;
	logic        rst;
	logic        cmd_valid;
	gbh_order_t  cmd_order;
	logic        cmd_ready;
	logic        cmd_done;
	logic        cmd_refused;
	logic [7:0]  rd_data;
	logic        reg_ack;
	logic [31:0] reg_rdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        slow;
	logic [7:0]  pin_byte;
	logic        seq_end;
	int          fails;
	int          checks;
	int          cyc;
	logic [1:0]  r;
	logic [7:0]  n0;

	gbh_host u_dut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_order(cmd_order), .cmd_ready(cmd_ready),
		.cmd_done(cmd_done), .cmd_refused(cmd_refused),
		.rd_data(rd_data), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata));

	gbh_dev_model u_dev (.clock(clock), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.slow(slow), .pin_byte(pin_byte), .seq_end(seq_end),
		.reg_ack(reg_ack), .reg_rdata(reg_rdata));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// returns {done, refused}; a hung order is caught by the cycle limit
	task automatic run(input gbh_cmd_t c, input logic [7:0] d,
		input logic [23:0] a, input logic [7:0] n, input logic x);
		@(negedge clock);
		while (cmd_ready !== 1'b1) @(negedge clock);
		cmd_order = '{cmd: c, data: d, addr: a, count: n, ext: x,
			tim: 4'h1, trigger_select_field: 4'h1, dma_timer_field: 8'h05};
		cmd_valid = 1'b1;
		@(negedge clock);
		cmd_valid = 1'b0;
		while (cmd_done !== 1'b1 && cmd_refused !== 1'b1) @(negedge clock);
		r = {cmd_done, cmd_refused};
	endtask

	task automatic end_seq();
		@(negedge clock);
		seq_end = 1'b1;
		@(negedge clock);
		seq_end = 1'b0;
	endtask

	task automatic t_init();
		run(CMD_INIT, 8'h00, 24'h0, 8'h00, 1'b0);
		check(r, 2'b10);
		for (int i = 0; i < 9; i++) begin
			check(u_dev.regs[i], (i == 5) ? 32'h06 : 32'h00);
		end
		check(u_dev.regs[9], 32'h11);
	endtask

	task automatic t_write();
		slow = 1'b1;
		n0 = u_dev.wr_cnt;
		run(CMD_WRITE, 8'h3c, 24'h0, 8'h00, 1'b0);
		check(r, 2'b10);
		check(u_dev.p5[3:0], 4'hc);
		check(u_dev.p7[7:4], 4'h3);
		check(u_dev.wr_cnt, n0 + 8'h1);
		run(CMD_STATUS, 8'h00, 24'h0, 8'h00, 1'b0);
		check(rd_data[6:5], 2'b10);
		n0 = u_dev.dma_cnt;
		end_seq();
		check(u_dev.dma_cnt, n0);
		run(CMD_STATUS, 8'h00, 24'h0, 8'h00, 1'b0);
		check(rd_data[6], 1'b0);
	endtask

	task automatic t_read();
		pin_byte = 8'ha5;
		n0 = u_dev.rd_cnt;
		run(CMD_READ_START, 8'h00, 24'h0, 8'h00, 1'b0);
		run(CMD_READ_FETCH, 8'h00, 24'h0, 8'h00, 1'b0);
		check(r, 2'b10);
		check(rd_data, 8'ha5);
		check(u_dev.rd_cnt, n0 + 8'h2);
		end_seq();
		slow = 1'b0;
	endtask

	task automatic t_dma_write();
		n0 = u_dev.wr_cnt;
		run(CMD_DMA_WRITE, 8'h5a, 24'h001000, 8'h10, 1'b0);
		check(r, 2'b10);
		check(u_dev.regs[11], 32'h144d);
		check(u_dev.regs[12], {24'h001001, 8'h10});
		check(u_dev.wr_cnt, n0 + 8'h1);
		run(CMD_STATUS, 8'h00, 24'h0, 8'h00, 1'b0);
		check(rd_data[7], 1'b1);
		run(CMD_WRITE, 8'h77, 24'h0, 8'h00, 1'b0);
		check(r, 2'b01);
		check(u_dev.wr_cnt, n0 + 8'h1);
		n0 = u_dev.dma_cnt;
		end_seq();
		check(u_dev.dma_cnt, n0 + 8'h1);
		run(CMD_STATUS, 8'h00, 24'h0, 8'h00, 1'b0);
		check(rd_data[7], 1'b0);
	endtask

	task automatic t_dma_read();
		for (int x = 1; x >= 0; x--) begin
			n0 = u_dev.rd_cnt;
			run(CMD_DMA_READ, 8'h00, 24'h002000, 8'h20, x[0]);
			check(r, 2'b10);
			check(u_dev.regs[11], 32'h1445);
			check(u_dev.regs[12], {24'h002000, 8'h20 + 8'(x)});
			check(u_dev.rd_cnt, n0 + 8'(1 - x));
			end_seq();
		end
	endtask

	task automatic t_channel();
		run(CMD_STALL, 8'h00, 24'h0, 8'h00, 1'b0);
		check(u_dev.regs[11][2:0], 3'h4);
		run(CMD_RESUME, 8'h00, 24'h0, 8'h00, 1'b0);
		check(u_dev.regs[11][0], 1'b1);
		run(CMD_TERMINATE, 8'h00, 24'h0, 8'h00, 1'b0);
		check(u_dev.regs[11][9:6], 4'h0);
		check(u_dev.regs[11][2:0], 3'h4);
		run(CMD_TERMINATE, 8'h01, 24'h0, 8'h00, 1'b0);
		check(u_dev.regs[11][2:0], 3'h0);
		run(CMD_OFF, 8'h00, 24'h0, 8'h00, 1'b0);
		check(r, 2'b10);
		check(u_dev.regs[9][3:0], 4'h0);
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end

	initial begin
		{rst, cmd_valid, slow, seq_end} = 4'b1000;
		cmd_order = '0;
		pin_byte = 8'h00;
		repeat (20) @(negedge clock);
		rst = 1'b0;
		t_init();
		t_write();
		t_read();
		t_dma_write();
		t_dma_read();
		t_channel();
		report_and_stop();
	end
endmodule
